/* rtl/ecr_pkg.sv */
// Purpose: Shared constants for the echo canceller control register bank
// Assumes: Byte-wide registers reached over the serial microport
// Notes: Command byte is read flag in bit 7, register address in bits 6:0
package ecr_pkg;
  // Register addresses
  localparam logic [6:0] ADDR_MAIN = 7'h00;
  localparam logic [6:0] ADDR_LINE = 7'h01;
  localparam logic [6:0] ADDR_ACOUSTIC = 7'h21;
  // Reset values and the value read at unmapped addresses
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [7:0] ACOUSTIC_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Main control fields
  localparam int MAIN_SHIFT_EN = 7;
  localparam int MAIN_RX_QUIET = 6;
  localparam int MAIN_TX_QUIET = 5;
  localparam int MAIN_TRANSPARENT = 4;
  localparam int MAIN_NARROWBAND_DETECT_DISABLE = 3;
  localparam int MAIN_AUTO_GAIN_DISABLE = 2;
  localparam int MAIN_HOWL_DETECT_DISABLE = 1;
  localparam int MAIN_SOFT_RESET = 0;
  // Canceller control fields
  localparam int CANC_LINE_SHIFT_SELECT = 7;
  localparam int CANC_NOISE_FILTER_DISABLE = 4;
  localparam int CANC_BYPASS = 0;
  // Command byte layout
  localparam int CMD_READ_BIT = 7;
  // Cycles taken by the power initialization routine
  localparam int INIT_CYCLES = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Serial port states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } ecr_state_t;
endpackage

/* rtl/ecr_ctrl_regs.sv */
// Purpose: Control register bank of the echo canceller, written over the serial microport
// Assumes: REF_CLK well above the serial clock; SAMPLE_SYNC marks each sample period
// Notes: Processing controls move only on a sample boundary; readback is immediate
//
// What this block does
// - Shift mode needs main bit 7 and line bit 7
// - Default signal limit when shift mode off
// - Main bit 6 quiets receive path output
// - Main bit 5 quiets send path output
// - Main bit 4 passes both paths transparently
// - Main bit 3 disables narrowband detectors
// - Main bit 2 disables automatic gain control
// - Main bit 1 disables howling detector
// - Writing main bit 0 presets all registers
// - Soft reset bit self-clears when initialization done
// - Canceller bit 4 disables noise filtering
`timescale 1ns/1ns
module ecr_ctrl_regs
  import ecr_pkg::*;
#(
  parameter int INIT_LEN = ecr_pkg::INIT_CYCLES // Length of the initialization routine
) (
  input wire logic REF_CLK, // Master clock, 10 MHz
  input wire logic RST_B, // Asynchronous reset, active low
  input wire logic SCLK, // Microport serial clock pin
  input wire logic CS_B, // Microport chip select pin, active low
  input wire logic DATA_IN, // Microport serial data in pin
  input wire logic SAMPLE_SYNC, // Sample period marker pin, rising edge
  output logic DATA_OUT, // Microport serial data out
  output logic DATA_OE, // Output enable for DATA_OUT
  output logic SHIFT_EN, // Two-bit shift mode active
  output logic DEFAULT_LIMIT_EN, // Default input limit active
  output logic RX_QUIET, // Receive output replaced by quiet code
  output logic TX_QUIET, // Send output replaced by quiet code
  output logic TRANSPARENT, // Both paths bypass processing
  output logic NB_DETECT_DIS, // Narrowband detectors disabled
  output logic AUTO_GAIN_DIS, // Automatic gain control disabled
  output logic HOWL_DETECT_DIS, // Howling detector disabled
  output logic AC_NOISE_FILTER_DIS, // Acoustic noise filtering disabled
  output logic LC_NOISE_FILTER_DIS, // Line noise filtering disabled
  output logic AC_BYPASS, // Acoustic echo estimate not subtracted
  output logic LC_BYPASS, // Line echo estimate not subtracted
  output logic INIT_BUSY // Initialization routine running
);
  import ecr_pkg::*;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic din_s1;
    logic din_s2;
    logic smp_s1;
    logic smp_s2;
    logic smp_d;
    ecr_state_t state;
    logic [2:0] bcnt;
    logic [7:0] shreg;
    logic rd;
    logic [6:0] addr;
    logic [7:0] tx;
    logic dout;
    logic doe;
    logic [7:0] main;
    logic [7:0] acoustic;
    logic [7:0] line;
    logic busy;
    logic [7:0] init_cnt;
    logic shift_en;
    logic limit_en;
    logic rx_quiet;
    logic tx_quiet;
    logic transparent;
    logic nb_dis;
    logic agc_dis;
    logic howl_dis;
    logic ac_nf_dis;
    logic lc_nf_dis;
    logic ac_byp;
    logic lc_byp;
  } ecr_regs_t;

  localparam ecr_regs_t REGS_RST = '{
    cs_s1: 1'b1, cs_s2: 1'b1, state: ST_IDLE, main: MAIN_RST, acoustic: ACOUSTIC_RST,
    line: LINE_RST, limit_en: 1'b1, default: '0};
  localparam logic [7:0] INIT_LOAD = 8'(INIT_LEN - 1);

  ecr_regs_t r;
  ecr_regs_t next_r;
  logic sclk_rise;
  logic sclk_fall;
  logic tick;
  logic [7:0] rx_byte;
  logic [7:0] rdata;
  logic wr_main;
  logic wr_go;

  // Edge detection reads only the second synchroniser stage and its delayed copy
  assign sclk_rise = r.sclk_s2 & ~r.sclk_d;
  assign sclk_fall = ~r.sclk_s2 & r.sclk_d;
  assign tick = r.smp_s2 & ~r.smp_d;
  assign rx_byte = {r.shreg[6:0], r.din_s2};

  // Register readback; unmapped addresses read as zero
  always_comb begin
    case (r.addr)
      ADDR_MAIN: rdata = r.main;
      ADDR_LINE: rdata = r.line;
      ADDR_ACOUSTIC: rdata = r.acoustic;
      default: rdata = UNMAPPED_READ;
    endcase
  end

  // A completed write byte; writes during initialization are dropped
  assign wr_go = (r.state == ST_DATA) && sclk_rise && (r.bcnt == LAST_BIT) && !r.rd && !r.busy;
  assign wr_main = wr_go && (r.addr == ADDR_MAIN);

  always_comb begin
    next_r = r;
    // Two-flop synchronisers on every pin
    next_r.cs_s1 = CS_B;
    next_r.cs_s2 = r.cs_s1;
    next_r.sclk_s1 = SCLK;
    next_r.sclk_s2 = r.sclk_s1;
    next_r.sclk_d = r.sclk_s2;
    next_r.din_s1 = DATA_IN;
    next_r.din_s2 = r.din_s1;
    next_r.smp_s1 = SAMPLE_SYNC;
    next_r.smp_s2 = r.smp_s1;
    next_r.smp_d = r.smp_s2;

    // Serial transfer: command byte, then one data byte in or out, MSB first
    if (r.cs_s2) begin
      next_r.state = ST_IDLE;
      next_r.bcnt = '0;
      next_r.doe = 1'b0;
    end else begin
      case (r.state)
        ST_IDLE: begin
          next_r.state = ST_CMD;
          next_r.bcnt = '0;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            next_r.shreg = rx_byte;
            next_r.bcnt = r.bcnt + 3'h1;
            if (r.bcnt == LAST_BIT) begin
              next_r.rd = rx_byte[CMD_READ_BIT];
              next_r.addr = rx_byte[6:0];
              next_r.state = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // Read data is loaded late, at the first fall of the data byte, from the newly latched address
          if (r.rd && r.bcnt == '0 && !r.doe) begin
            next_r.tx = rdata;
          end
          if (r.rd && sclk_fall) begin
            next_r.dout = (r.bcnt == '0 && !r.doe) ? rdata[7] : r.tx[7];
            next_r.tx = (r.bcnt == '0 && !r.doe) ? {rdata[6:0], 1'b0} : {r.tx[6:0], 1'b0};
            next_r.doe = 1'b1;
          end
          if (sclk_rise) begin
            next_r.shreg = rx_byte;
            next_r.bcnt = r.bcnt + 3'h1;
            if (r.bcnt == LAST_BIT) begin
              next_r.state = ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // Extra clocks in one select are ignored; the output lets go after the last bit
          if (sclk_fall) begin
            next_r.doe = 1'b0;
          end
        end
        default: next_r.state = ST_IDLE;
      endcase
    end

    // Register writes; all bits store as written
    if (wr_go) begin
      case (r.addr)
        ADDR_MAIN: next_r.main = rx_byte;
        ADDR_LINE: next_r.line = rx_byte;
        ADDR_ACOUSTIC: next_r.acoustic = rx_byte;
        default: ;
      endcase
    end

    // Soft reset starts the routine, keeps the bit set, then presets and clears it
    if (wr_main && rx_byte[MAIN_SOFT_RESET]) begin
      next_r.busy = 1'b1;
      next_r.init_cnt = INIT_LOAD;
    end else if (r.busy) begin
      if (r.init_cnt == '0) begin
        next_r.busy = 1'b0;
        next_r.main = MAIN_RST;
        next_r.line = LINE_RST;
        next_r.acoustic = ACOUSTIC_RST;
        next_r.main[MAIN_SOFT_RESET] = 1'b0;
      end else begin
        next_r.init_cnt = r.init_cnt - 8'h01;
      end
    end

    // Processing controls change only at a sample boundary so a sample is never split
    if (tick) begin
      next_r.shift_en = r.main[MAIN_SHIFT_EN] & r.line[CANC_LINE_SHIFT_SELECT];
      next_r.limit_en = ~(r.main[MAIN_SHIFT_EN] & r.line[CANC_LINE_SHIFT_SELECT]);
      next_r.rx_quiet = r.main[MAIN_RX_QUIET];
      next_r.tx_quiet = r.main[MAIN_TX_QUIET];
      next_r.transparent = r.main[MAIN_TRANSPARENT];
      next_r.nb_dis = r.main[MAIN_NARROWBAND_DETECT_DISABLE];
      next_r.agc_dis = r.main[MAIN_AUTO_GAIN_DISABLE];
      next_r.howl_dis = r.main[MAIN_HOWL_DETECT_DISABLE];
      next_r.ac_nf_dis = r.acoustic[CANC_NOISE_FILTER_DISABLE];
      next_r.lc_nf_dis = r.line[CANC_NOISE_FILTER_DISABLE];
      next_r.ac_byp = r.acoustic[CANC_BYPASS];
      next_r.lc_byp = r.line[CANC_BYPASS];
    end
  end

  // Single state register
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign DATA_OUT = r.dout;
  assign DATA_OE = r.doe;
  assign SHIFT_EN = r.shift_en;
  assign DEFAULT_LIMIT_EN = r.limit_en;
  assign RX_QUIET = r.rx_quiet;
  assign TX_QUIET = r.tx_quiet;
  assign TRANSPARENT = r.transparent;
  assign NB_DETECT_DIS = r.nb_dis;
  assign AUTO_GAIN_DIS = r.agc_dis;
  assign HOWL_DETECT_DIS = r.howl_dis;
  assign AC_NOISE_FILTER_DIS = r.ac_nf_dis;
  assign LC_NOISE_FILTER_DIS = r.lc_nf_dis;
  assign AC_BYPASS = r.ac_byp;
  assign LC_BYPASS = r.lc_byp;
  assign INIT_BUSY = r.busy;

  // Checks on the control outputs and the soft reset sequence
  localparam int InitBound = INIT_LEN + 1;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  property p_shift;
    tick |=> SHIFT_EN == $past(r.main[MAIN_SHIFT_EN] && r.line[CANC_LINE_SHIFT_SELECT]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift mode mismatch");

  property p_limit;
    DEFAULT_LIMIT_EN != SHIFT_EN;
  endproperty
  a_limit: assert property (p_limit) else $error("default limit not opposite shift");

  property p_rx_quiet;
    tick |=> RX_QUIET == $past(r.main[MAIN_RX_QUIET]);
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("receive quiet mismatch");

  property p_tx_quiet;
    tick |=> TX_QUIET == $past(r.main[MAIN_TX_QUIET]);
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("send quiet mismatch");

  property p_transparent;
    tick |=> TRANSPARENT == $past(r.main[MAIN_TRANSPARENT]);
  endproperty
  a_transparent: assert property (p_transparent) else $error("transparent mismatch");

  property p_detectors;
    tick |=> {NB_DETECT_DIS, AUTO_GAIN_DIS, HOWL_DETECT_DIS} == $past({r.main[MAIN_NARROWBAND_DETECT_DISABLE],
      r.main[MAIN_AUTO_GAIN_DISABLE], r.main[MAIN_HOWL_DETECT_DISABLE]});
  endproperty
  a_detectors: assert property (p_detectors) else $error("detector disables mismatch");

  property p_noise;
    tick |=> {AC_NOISE_FILTER_DIS, LC_NOISE_FILTER_DIS} ==
      $past({r.acoustic[CANC_NOISE_FILTER_DISABLE], r.line[CANC_NOISE_FILTER_DISABLE]});
  endproperty
  a_noise: assert property (p_noise) else $error("noise filter disable mismatch");

  property p_ac_bypass;
    tick |=> AC_BYPASS == $past(r.acoustic[CANC_BYPASS]);
  endproperty
  a_ac_bypass: assert property (p_ac_bypass) else $error("acoustic bypass mismatch");

  property p_hold;
    !tick |=> $stable({RX_QUIET, TX_QUIET, TRANSPARENT, SHIFT_EN, AC_BYPASS});
  endproperty
  a_hold: assert property (p_hold) else $error("control changed off a sample boundary");

  property p_init_start;
    wr_main && rx_byte[MAIN_SOFT_RESET] |=> INIT_BUSY && r.main[MAIN_SOFT_RESET];
  endproperty
  a_init_start: assert property (p_init_start) else $error("soft reset did not start");

  property p_init_end;
    $rose(INIT_BUSY) |-> ##[1:InitBound] (!INIT_BUSY && r.main == MAIN_RST && r.line == LINE_RST);
  endproperty
  a_init_end: assert property (p_init_end) else $error("initialization did not complete");

  property p_reset_bit;
    INIT_BUSY |-> r.main[MAIN_SOFT_RESET];
  endproperty
  a_reset_bit: assert property (p_reset_bit) else $error("reset bit cleared early");

endmodule

/* dv/test_ecr_ctrl_regs.sv */
// Purpose: Self-checking bench for the echo canceller control register bank
// Assumes: Host speaks the serial microport, command byte then data byte, MSB first
// Notes: Expected values come from a shadow copy of the three registers
`timescale 1ns/1ns
module test_ecr_ctrl_regs;
  import ecr_pkg::*;
  localparam int INIT_LEN_TB = 40; // Long enough to still be busy when the write task returns
  logic REF_CLK, RST_B, SCLK, CS_B, DATA_IN, SAMPLE_SYNC;
  logic DATA_OUT, DATA_OE, SHIFT_EN, DEFAULT_LIMIT_EN, RX_QUIET, TX_QUIET, TRANSPARENT;
  logic NB_DETECT_DIS, AUTO_GAIN_DIS, HOWL_DETECT_DIS, AC_NOISE_FILTER_DIS, LC_NOISE_FILTER_DIS;
  logic AC_BYPASS, LC_BYPASS, INIT_BUSY;
  logic [12:0] outs;
  logic [7:0] m, l, a, rdv;
  logic [7:0] oe_hist; // Output enable seen before each data-byte rising edge
  logic busy;
  int miscompares, num_checks;
  // All processing controls gathered so one compare covers them
  assign outs = {INIT_BUSY, SHIFT_EN, DEFAULT_LIMIT_EN, RX_QUIET, TX_QUIET, TRANSPARENT, NB_DETECT_DIS,
                 AUTO_GAIN_DIS, HOWL_DETECT_DIS, AC_NOISE_FILTER_DIS, LC_NOISE_FILTER_DIS, AC_BYPASS, LC_BYPASS};
  ecr_ctrl_regs #(.INIT_LEN(INIT_LEN_TB)) ecr_ctrl_regs_inst (.REF_CLK(REF_CLK), .RST_B(RST_B), .SCLK(SCLK),
    .CS_B(CS_B), .DATA_IN(DATA_IN), .SAMPLE_SYNC(SAMPLE_SYNC), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
    .SHIFT_EN(SHIFT_EN), .DEFAULT_LIMIT_EN(DEFAULT_LIMIT_EN), .RX_QUIET(RX_QUIET), .TX_QUIET(TX_QUIET),
    .TRANSPARENT(TRANSPARENT), .NB_DETECT_DIS(NB_DETECT_DIS), .AUTO_GAIN_DIS(AUTO_GAIN_DIS),
    .HOWL_DETECT_DIS(HOWL_DETECT_DIS), .AC_NOISE_FILTER_DIS(AC_NOISE_FILTER_DIS),
    .LC_NOISE_FILTER_DIS(LC_NOISE_FILTER_DIS), .AC_BYPASS(AC_BYPASS), .LC_BYPASS(LC_BYPASS),
    .INIT_BUSY(INIT_BUSY));
  // Master clock, 100 ns period
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  // Expected controls from the shadow registers
  function automatic logic [12:0] exp_outs();
    return {busy, m[7] & l[7], ~(m[7] & l[7]), m[6:1], a[4], l[4], a[0], l[0]};
  endfunction
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected register value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_outs();
    num_checks++;
    if (outs !== exp_outs()) begin
      miscompares++;
      $display("unexpected controls at %0t: got %h expected %h", $time, outs, exp_outs());
    end
  endtask
  // One transfer; each SCLK level is held at least six clocks so the synchronisers see it
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
    logic [15:0] w;
    w = {cmd, dat};
    rd = 8'h00;
    CS_B <= 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      DATA_IN <= w[i];
      tick(6);
      @(negedge REF_CLK);
      if (i < 8) rd[i] = DATA_OUT;
      if (i < 8) oe_hist[i] = DATA_OE;
      @(posedge REF_CLK);
      SCLK <= 1'b1;
      tick(6);
      SCLK <= 1'b0;
    end
    tick(6);
    CS_B <= 1'b1;
    tick(6);
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    logic [7:0] unused;
    xfer({1'b0, ad}, d, unused);
    // A write must never turn the data output on
    chk_reg(oe_hist, 8'h00);
  endtask
  task automatic rd_chk(input logic [6:0] ad, input logic [7:0] exp);
    logic [7:0] v;
    xfer({1'b1, ad}, 8'h00, v);
    chk_reg(v, exp);
    // Output driven through the whole data byte, released once the select ends
    chk_reg(oe_hist, 8'hff);
    chk_reg({7'h00, DATA_OE}, 8'h00);
  endtask
  // One sample boundary; controls settle a few clocks after the rise
  task automatic sample();
    SAMPLE_SYNC <= 1'b1;
    tick(2);
    SAMPLE_SYNC <= 1'b0;
    tick(6);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog sized well past the roughly 6500 clocks the sequence needs
  initial begin
    tick(30000);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    miscompares = 0;
    num_checks = 0;
    RST_B = 1'b0;
    SCLK = 1'b0;
    CS_B = 1'b1;
    DATA_IN = 1'b0;
    SAMPLE_SYNC = 1'b0;
    {m, l, a, busy} = '0;
    tick(12);
    RST_B <= 1'b1;
    tick(4);
    chk_outs();
    rd_chk(ADDR_MAIN, MAIN_RST);
    rd_chk(ADDR_LINE, LINE_RST);
    rd_chk(ADDR_ACOUSTIC, ACOUSTIC_RST);
    // Unmapped place ignores writes and reads as zero
    wr(7'h05, 8'hff);
    rd_chk(7'h05, UNMAPPED_READ);
    // Shift bit alone leaves shift mode off and the default limit on
    wr(ADDR_MAIN, 8'h80);
    m = 8'h80;
    sample();
    chk_outs();
    // Canceller controls, held back until the next sample boundary
    wr(ADDR_LINE, 8'h91);
    wr(ADDR_ACOUSTIC, 8'h11);
    chk_outs();
    l = 8'h91;
    a = 8'h11;
    sample();
    chk_outs();
    rd_chk(ADDR_LINE, 8'h91);
    rd_chk(ADDR_ACOUSTIC, 8'h11);
    // Main control bits 7 to 1 each alone, walking down from the shift bit
    for (int b = 7; b >= 1; b--) begin
      wr(ADDR_MAIN, 8'h01 << b);
      chk_outs();
      m = 8'h01 << b;
      sample();
      chk_outs();
      rd_chk(ADDR_MAIN, m);
    end
    // Soft reset presets everything and then clears its own bit
    wr(ADDR_MAIN, 8'h01);
    busy = 1'b1;
    chk_outs();
    busy = 1'b0;
    tick(INIT_LEN_TB);
    for (int n = 0; n < 4; n++) begin
      xfer({1'b1, ADDR_MAIN}, 8'h00, rdv);
      if (rdv[MAIN_SOFT_RESET] === 1'b0) break;
    end
    chk_reg(rdv, MAIN_RST);
    rd_chk(ADDR_LINE, LINE_RST);
    rd_chk(ADDR_ACOUSTIC, ACOUSTIC_RST);
    {m, l, a} = '0;
    sample();
    chk_outs();
    print_verdict();
  end
endmodule
